// *** rtl/pdlc_pkg.sv ***
// Shared constants and types of the converter control register bank
package pdlc_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONV_CTRL2 = 8'h05;
   localparam logic [7:0] ADDR_CORE_CODE = 8'h06;
   localparam logic [7:0] ADDR_SLEW = 8'h07;
   localparam logic [7:0] ADDR_LIN = 8'h08;

   // ----------------------------------------------------------------
   // Field positions, write masks and reset values
   // ----------------------------------------------------------------
   localparam int TRIG_BIT = 7;
   localparam int PINSEL_BIT = 6;
   localparam logic [7:0] CONV_CTRL2_WMASK = 8'hC7;
   localparam logic [7:0] CORE_WMASK = 8'h1F;
   localparam logic [7:0] SLEW_WMASK = 8'h07;
   localparam logic [7:0] LIN_WMASK = 8'h77;
   localparam logic [7:0] CONV_CTRL2_RST = 8'h40;
   localparam logic [7:0] CORE_RST_LO = 8'h14;
   localparam logic [7:0] CORE_RST_HI = 8'h1E;
   localparam logic [7:0] SLEW_RST = 8'h06;
   localparam logic [7:0] LIN_RST = 8'h00;
   localparam logic [4:0] PIN_CODE_LO = 5'h10;
   localparam logic [4:0] PIN_CODE_HI = 5'h1F;
   localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
   // Linear regulator defaults, indexed by {pin_b, pin_a}
   localparam logic [3:0][7:0] LIN_DEF_TABLE = {
      8'h77, 8'h53, 8'h35, 8'h11
   };

   // ----------------------------------------------------------------
   // Pin synchroniser bit positions
   // ----------------------------------------------------------------
   localparam int SYNC_W = 7;
   localparam int SY_CORE = 0;
   localparam int SY_LA = 1;
   localparam int SY_LB = 2;
   localparam int SY_WARM_N = 3;
   localparam int SY_UNDERVOLTAGE_LOCKOUT = 4;
   localparam int SY_POR = 5;
   localparam int SY_BKP = 6;
   // Warm reset pin idles high so release does not look like an event
   localparam logic [6:0] SYNC_RST = 7'h08;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int STEP_UV = 25000;
   localparam int BASE_RATE_UV_PER_US = 225;
   localparam int CLK_MHZ = 40;
   localparam int BASE_STEP_NS = STEP_UV * 1000 / BASE_RATE_UV_PER_US;
   localparam int STEP_BASE_CYC_DEF = BASE_STEP_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 13;
   localparam logic [1:0] INIT_CYC = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pdlc_bus_t;

   typedef struct packed {
      logic [6:0] meta;
      logic [6:0] stable;
   } pdlc_sync_st_t;

   typedef struct packed {
      logic [4:0] code;
      logic [CNT_W-1:0] cnt;
      logic at_target;
   } pdlc_ramp_st_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] core;
      logic [7:0] slew;
      logic [7:0] lin;
      logic [7:0] rdata;
      logic [4:0] core_out;
      logic [2:0] dis;
      logic [1:0] init;
   } pdlc_top_st_t;

   localparam pdlc_top_st_t TOP_RST = '{
      ctrl: CONV_CTRL2_RST, core: CORE_RST_LO, slew: SLEW_RST,
      lin: LIN_RST, rdata: 8'h00, core_out: PIN_CODE_LO,
      dis: 3'h0, init: INIT_CYC
   };

   // Cycles per 25 mV step; each rate code halves the interval
   function automatic logic [CNT_W-1:0] step_interval(
      input logic [2:0] rate,
      input logic [CNT_W-1:0] base
   );
      logic [CNT_W-1:0] v;
      v = base >> rate;
      if (v == '0) begin
         v = {{(CNT_W-1){1'b0}}, 1'b1};
      end
      return v;
   endfunction

   function automatic logic [7:0] core_default(input logic pin);
      return pin ? CORE_RST_HI : CORE_RST_LO;
   endfunction

endpackage

// *** rtl/pdlc_sync.sv ***
// Two-flop synchroniser for the asynchronous pins
`timescale 1ns/10ps
module pdlc_sync (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Pins
   input wire logic [6:0] i_async,
   output logic [6:0] o_sync
);

   pdlc_pkg::pdlc_sync_st_t q;
   pdlc_pkg::pdlc_sync_st_t d;

   // Meta stage feeds only the stable stage
   always_comb begin
      d = q;
      d.meta = i_async;
      d.stable = q.meta;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '{meta: pdlc_pkg::SYNC_RST, stable: pdlc_pkg::SYNC_RST};
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_sync = q.stable;

endmodule

// *** rtl/pdlc_ramp.sv ***
// Voltage code ramp engine for the core buck
`timescale 1ns/10ps
module pdlc_ramp #(
   parameter int STEP_BASE_CYC = pdlc_pkg::STEP_BASE_CYC_DEF
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Control
   input wire logic i_run,
   input wire logic [4:0] i_target,
   input wire logic [2:0] i_rate,
   input wire logic i_load,
   input wire logic [4:0] i_load_code,
   // Status
   output logic [4:0] o_code,
   output logic o_at_target
);

   localparam logic [pdlc_pkg::CNT_W-1:0] BASE =
      pdlc_pkg::CNT_W'(STEP_BASE_CYC);

   pdlc_pkg::pdlc_ramp_st_t q;
   pdlc_pkg::pdlc_ramp_st_t d;
   logic [pdlc_pkg::CNT_W-1:0] interval;

   // Target is read live, so a rewrite mid-ramp bends the path
   always_comb begin
      d = q;
      d.at_target = 1'b0;
      interval = pdlc_pkg::step_interval(i_rate, BASE);
      if (i_load) begin
         d.code = i_load_code;
         d.cnt = '0;
      end else if (i_run) begin
         if (q.code == i_target) begin
            d.at_target = 1'b1;
            d.cnt = '0;
         end else if (i_rate == pdlc_pkg::SLEW_IMMEDIATE) begin
            d.code = i_target;
            d.cnt = '0;
         end else if (q.cnt >= interval - 1'b1) begin
            d.cnt = '0;
            d.code = (q.code < i_target) ? q.code + 5'h1 : q.code - 5'h1;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end else begin
         d.cnt = '0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '{code: pdlc_pkg::CORE_RST_LO[4:0], cnt: '0, at_target: 1'b0};
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_code = q.code;
   assign o_at_target = q.at_target;

endmodule

// *** rtl/pdlc_top.sv ***
// Converter control, core voltage, slew and linear regulator registers
//
// Functional notes
// - Trigger write ramps core code at slew rate
// - Trigger clear keeps core voltage unchanged
// - Trigger self-clears when internal code hits target
// - Pin-select chooses register or default pin voltage
// - Pin-select returns to one on reset events
// - Discharge bits act while their converter disabled
// - Core code: 0.8 V plus 25 mV steps
// - Core default bit4 set, low bits from pin
// - Core register reloads on all reset events
// - Slew code doubles rate; top code immediate
// - Slew register bits 2-0 default 110
// - Linear codes: b in 6-4, a in 2-0
// - Undervoltage loads linear codes from default pins
// - Converter control at 05h, resets to 40h
`timescale 1ns/10ps
module pdlc_top #(
   parameter int STEP_BASE_CYC = pdlc_pkg::STEP_BASE_CYC_DEF
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Register port
   input wire pdlc_pkg::pdlc_bus_t i_bus,
   output logic [7:0] o_rdata,
   // Pins and reset sources
   input wire logic i_core_default_pin,
   input wire logic i_linear_default_pin_a,
   input wire logic i_linear_default_pin_b,
   input wire logic i_warm_reset_pin_n,
   input wire logic i_undervoltage_lockout,
   input wire logic i_power_on_reset_out,
   input wire logic i_backup_supply_low,
   // Converter state
   input wire logic [2:0] i_conv_enabled,
   // Regulator controls
   output logic [4:0] o_core_code,
   output logic [2:0] o_lin_a_code,
   output logic [2:0] o_lin_b_code,
   output logic [2:0] o_discharge,
   output logic o_trigger_busy
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [6:0] pins_raw;
   logic [6:0] sy;

   assign pins_raw = {i_backup_supply_low, i_power_on_reset_out,
                      i_undervoltage_lockout, i_warm_reset_pin_n,
                      i_linear_default_pin_b, i_linear_default_pin_a,
                      i_core_default_pin};

   pdlc_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_async(pins_raw),
      .o_sync(sy)
   );

   // ----------------------------------------------------------------
   // Reset events
   // ----------------------------------------------------------------
   pdlc_pkg::pdlc_top_st_t q;
   pdlc_pkg::pdlc_top_st_t d;
   logic undervoltage_lockout_ev;
   logic full_ev;
   logic core_pin;
   logic [7:0] core_def;
   logic [7:0] lin_def;

   // Init cycles stand in for undervoltage so pin defaults are caught
   // only once the synchroniser holds real pin levels
   assign undervoltage_lockout_ev = sy[pdlc_pkg::SY_UNDERVOLTAGE_LOCKOUT] || (q.init != 2'h0);
   assign full_ev = undervoltage_lockout_ev || !sy[pdlc_pkg::SY_WARM_N] ||
                    sy[pdlc_pkg::SY_POR] || sy[pdlc_pkg::SY_BKP];
   assign core_pin = sy[pdlc_pkg::SY_CORE];
   assign core_def = pdlc_pkg::core_default(core_pin);
   assign lin_def = pdlc_pkg::LIN_DEF_TABLE[{sy[pdlc_pkg::SY_LB],
                                              sy[pdlc_pkg::SY_LA]}];

   // ----------------------------------------------------------------
   // Ramp engine
   // ----------------------------------------------------------------
   logic [4:0] ramp_code;
   logic ramp_at;

   pdlc_ramp #(
      .STEP_BASE_CYC(STEP_BASE_CYC)
   ) u_ramp (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_run(q.ctrl[pdlc_pkg::TRIG_BIT]),
      .i_target(q.core[4:0]),
      .i_rate(q.slew[2:0]),
      .i_load(full_ev),
      .i_load_code(core_def[4:0]),
      .o_code(ramp_code),
      .o_at_target(ramp_at)
   );

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   function automatic logic [7:0] reg_read(
      input pdlc_pkg::pdlc_top_st_t s,
      input logic [7:0] addr
   );
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         pdlc_pkg::ADDR_CONV_CTRL2: v = s.ctrl;
         pdlc_pkg::ADDR_CORE_CODE: v = s.core;
         pdlc_pkg::ADDR_SLEW: v = s.slew;
         pdlc_pkg::ADDR_LIN: v = s.lin;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   logic wr_go;

   assign wr_go = i_bus.wr && (i_bus.addr == pdlc_pkg::ADDR_CONV_CTRL2) &&
                  i_bus.wdata[pdlc_pkg::TRIG_BIT];

   always_comb begin
      d = q;
      if (q.init != 2'h0) begin
         d.init = 2'(q.init - 2'h1);
      end
      // Self clear first, so a write of the trigger in the same cycle wins
      if (q.ctrl[pdlc_pkg::TRIG_BIT] && ramp_at && !wr_go) begin
         d.ctrl[pdlc_pkg::TRIG_BIT] = 1'b0;
      end
      if (i_bus.wr) begin
         case (i_bus.addr)
            pdlc_pkg::ADDR_CONV_CTRL2: begin
               d.ctrl = i_bus.wdata & pdlc_pkg::CONV_CTRL2_WMASK;
            end
            pdlc_pkg::ADDR_CORE_CODE: begin
               d.core = i_bus.wdata & pdlc_pkg::CORE_WMASK;
            end
            pdlc_pkg::ADDR_SLEW: begin
               d.slew = i_bus.wdata & pdlc_pkg::SLEW_WMASK;
            end
            pdlc_pkg::ADDR_LIN: begin
               // Reserved bits dropped even if software breaks the habit
               d.lin = i_bus.wdata & pdlc_pkg::LIN_WMASK;
            end
            default: begin
               d.ctrl = d.ctrl;
            end
         endcase
      end
      // Reset events override a same-cycle write only in the fields they reload
      if (undervoltage_lockout_ev) begin
         d.ctrl[pdlc_pkg::TRIG_BIT] = 1'b0;
         d.ctrl[2:0] = 3'h0;
         d.slew = pdlc_pkg::SLEW_RST;
         d.lin = lin_def;
      end
      if (full_ev) begin
         d.ctrl[pdlc_pkg::PINSEL_BIT] = 1'b1;
         d.core = core_def;
      end
      // Pin-select picks the pin default, else the ramped code
      if (q.ctrl[pdlc_pkg::PINSEL_BIT]) begin
         d.core_out = core_pin ? pdlc_pkg::PIN_CODE_HI :
                                 pdlc_pkg::PIN_CODE_LO;
      end else begin
         d.core_out = ramp_code;
      end
      d.dis = q.ctrl[2:0] & ~i_conv_enabled;
      if (i_bus.rd) begin
         d.rdata = reg_read(q, i_bus.addr);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= pdlc_pkg::TOP_RST;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata = q.rdata;
   assign o_core_code = q.core_out;
   assign o_lin_a_code = q.lin[2:0];
   assign o_lin_b_code = q.lin[6:4];
   assign o_discharge = q.dis;
   assign o_trigger_busy = q.ctrl[pdlc_pkg::TRIG_BIT];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n || !i_clk_en);

   a_trig_self_clear: assert property (
      q.ctrl[7] && ramp_at && !wr_go && !i_bus.wr |=> !q.ctrl[7])
      else $error("trigger not cleared at target");

   a_hold_no_trig: assert property (
      !q.ctrl[7] && !full_ev |=> $stable(ramp_code))
      else $error("core code moved without trigger");

   a_pinsel_source: assert property (
      q.ctrl[6] |=> o_core_code ==
         ($past(core_pin) ? 5'h1F : 5'h10))
      else $error("pin-select output code wrong");

   a_pinsel_reload: assert property (
      full_ev |=> q.ctrl[6])
      else $error("pin-select not restored");

   a_core_reload: assert property (
      full_ev |=> q.core == ($past(core_pin) ? 8'h1E : 8'h14))
      else $error("core code default wrong");

   a_core_reserved: assert property (
      q.core[7:5] == 3'h0)
      else $error("core reserved bits set");

   a_slew_reload: assert property (
      undervoltage_lockout_ev |=> q.slew == 8'h06)
      else $error("slew default wrong");

   a_lin_reload: assert property (
      undervoltage_lockout_ev |=> q.lin == $past(lin_def))
      else $error("linear defaults not from pins");

   a_lin_reserved: assert property (
      q.lin[7] == 1'b0 && q.lin[3] == 1'b0)
      else $error("linear reserved bits set");

   a_discharge_gate: assert property (
      ##1 o_discharge == ($past(q.ctrl[2:0]) & ~$past(i_conv_enabled)))
      else $error("discharge gating wrong");

   a_trig_immediate: assert property (
      q.ctrl[7] && q.slew[2:0] == 3'h7 && !full_ev && !i_bus.wr
      |-> ##[1:2] ramp_code == q.core[4:0])
      else $error("immediate transition missed");

   a_trig_set_wins: assert property (
      wr_go && !undervoltage_lockout_ev |=> q.ctrl[7])
      else $error("trigger write lost");

   a_write_pinsel: assert property (
      i_bus.wr && i_bus.addr == 8'h05 && !full_ev
      |=> q.ctrl[6] == $past(i_bus.wdata[6]))
      else $error("pin-select write lost");

   a_write_discharge: assert property (
      i_bus.wr && i_bus.addr == 8'h05 && !undervoltage_lockout_ev
      |=> q.ctrl[2:0] == $past(i_bus.wdata[2:0]))
      else $error("discharge write lost");

   a_write_core: assert property (
      i_bus.wr && i_bus.addr == 8'h06 && !full_ev
      |=> q.core == {3'h0, $past(i_bus.wdata[4:0])})
      else $error("core code write lost");

   a_write_slew: assert property (
      i_bus.wr && i_bus.addr == 8'h07 && !undervoltage_lockout_ev
      |=> q.slew == {5'h00, $past(i_bus.wdata[2:0])})
      else $error("slew write lost");

   a_write_lin: assert property (
      i_bus.wr && i_bus.addr == 8'h08 && !undervoltage_lockout_ev
      |=> q.lin[6:4] == $past(i_bus.wdata[6:4]) &&
          q.lin[2:0] == $past(i_bus.wdata[2:0]))
      else $error("linear code write lost");

   a_core_follow: assert property (
      !q.ctrl[6] |=> o_core_code == $past(ramp_code))
      else $error("core output not from ramp");

   a_ramp_one_step: assert property (
      q.ctrl[7] && q.slew[2:0] != 3'h7 && !full_ev
      |=> ramp_code == $past(ramp_code) ||
          ramp_code == 5'($past(ramp_code) + 5'h01) ||
          ramp_code == 5'($past(ramp_code) - 5'h01))
      else $error("ramp moved more than one step");

   a_ramp_toward: assert property (
      q.ctrl[7] && !full_ev && ramp_code < q.core[4:0]
      |=> ramp_code > $past(ramp_code) ||
          ramp_code == $past(ramp_code))
      else $error("ramp moved away from target");

   a_read_ctrl: assert property (
      i_bus.rd && i_bus.addr == 8'h05 |=> o_rdata == $past(q.ctrl))
      else $error("control read wrong");

   c_trigger_run: cover property (!q.ctrl[7] ##1 q.ctrl[7]);
   c_trigger_done: cover property (q.ctrl[7] ##1 !q.ctrl[7]);
   c_pinsel_off: cover property (q.ctrl[6] ##1 !q.ctrl[6]);
   c_step_ramp: cover property (q.ctrl[7] && q.slew[2:0] == 3'h6 &&
                                ramp_code != q.core[4:0]);
   c_retarget: cover property (q.ctrl[7] && i_bus.wr && i_bus.addr == 8'h06);

endmodule

// *** dv/pdlc_host.sv ***
// Host model that issues single-byte register accesses
`timescale 1ns/10ps
module pdlc_host (
   // Clock
   input wire logic i_ref_clk,
   // Register port
   output pdlc_pkg::pdlc_bus_t o_bus,
   input wire logic [7:0] i_rdata
);
   initial o_bus = '0;

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   // Idle lines show the inverse so stale values cannot pass as good
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == pdlc_pkg::ADDR_LIN) begin
         v = d & 8'h77;
      end
      @(posedge i_ref_clk);
      o_bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
      @(posedge i_ref_clk);
      o_bus <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~v};
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      o_bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(posedge i_ref_clk);
      o_bus <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hFF};
      #1;
      d = i_rdata;
   endtask
endmodule

// *** dv/pmic_dvs_linear_reg_voltage_regs_tb.sv ***
// Self-checking bench for the converter control register bank
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
      end \
   end
module pmic_dvs_linear_reg_voltage_regs_tb;
   localparam int STEP = 64;
   logic i_ref_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic core_pin = 1'h0;
   logic pin_a = 1'h0;
   logic pin_b = 1'h0;
   // Reset sources: warm, undervoltage, power-on, backup
   logic [3:0] src = 4'h0;
   logic [2:0] conv_en = 3'h7;
   logic clk_en = 1'h1;
   pdlc_pkg::pdlc_bus_t bus;
   logic [7:0] rdata;
   logic [4:0] core_code;
   logic [2:0] lin_a;
   logic [2:0] lin_b;
   logic [2:0] dis;
   logic busy;
   logic [4:0] mid;
   logic [4:0] tgt;
   int n_mismatch = 0;
   int total_checks = 0;
   int n;
   int iv;

   always #12.5 i_ref_clk = ~i_ref_clk;

   pdlc_top #(.STEP_BASE_CYC(STEP)) pdlc_top_i (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
      .i_bus(bus), .o_rdata(rdata), .i_core_default_pin(core_pin),
      .i_linear_default_pin_a(pin_a), .i_linear_default_pin_b(pin_b),
      .i_warm_reset_pin_n(~src[0]), .i_undervoltage_lockout(src[1]),
      .i_power_on_reset_out(src[2]), .i_backup_supply_low(src[3]),
      .i_conv_enabled(conv_en), .o_core_code(core_code),
      .o_lin_a_code(lin_a), .o_lin_b_code(lin_b), .o_discharge(dis),
      .o_trigger_busy(busy)
   );

   pdlc_host pdlc_host_i (
      .i_ref_clk(i_ref_clk), .o_bus(bus), .i_rdata(rdata)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      pdlc_host_i.write_reg(a, d);
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      pdlc_host_i.read_reg(a, v);
      `CHK(v, e)
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge i_ref_clk);
   endtask

   // Bounded wait for the trigger bit to drop
   task automatic wait_idle(output int c);
      c = 0;
      #1;
      while (busy !== 1'h0 && c < 3000) begin
         @(posedge i_ref_clk);
         #1;
         c++;
      end
      if (c >= 3000) n_mismatch++;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      cyc(12);
      i_rst_n <= 1'h1;
      cyc(6);
      chk_reg(pdlc_pkg::ADDR_CONV_CTRL2, 8'h40);
      chk_reg(pdlc_pkg::ADDR_CORE_CODE, 8'h14);
      chk_reg(pdlc_pkg::ADDR_SLEW, 8'h06);
      chk_reg(pdlc_pkg::ADDR_LIN, 8'h11);
      chk_reg(8'h09, 8'h00);
      `CHK(core_code, 5'h10)
      wr(pdlc_pkg::ADDR_CORE_CODE, 8'hFF);
      chk_reg(pdlc_pkg::ADDR_CORE_CODE, 8'h1F);
      wr(pdlc_pkg::ADDR_SLEW, 8'hFF);
      chk_reg(pdlc_pkg::ADDR_SLEW, 8'h07);
      wr(pdlc_pkg::ADDR_LIN, 8'hFF);
      chk_reg(pdlc_pkg::ADDR_LIN, 8'h77);
      wr(pdlc_pkg::ADDR_LIN, 8'h25);
      cyc(2);
      `CHK({lin_b, lin_a}, 6'h15)
      // Discharge only on disabled converters
      conv_en <= 3'h2;
      wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h07);
      cyc(3);
      `CHK(dis, 3'h5)
      conv_en <= 3'h7;
      cyc(3);
      `CHK(dis, 3'h0)
      // Register path selected, but no trigger yet
      cyc(20);
      `CHK(core_code, 5'h14)
      wr(pdlc_pkg::ADDR_SLEW, 8'h07);
      wr(pdlc_pkg::ADDR_CORE_CODE, 8'h18);
      wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h87);
      wait_idle(n);
      `CHK(core_code, 5'h18)
      `CHK(n <= 5, 1'h1)
      chk_reg(pdlc_pkg::ADDR_CONV_CTRL2, 8'h07);
      // Four steps at every graded rate
      for (int r = 0; r < 7; r++) begin
         tgt = (r % 2 == 0) ? 5'h1C : 5'h18;
         iv = STEP >> r;
         wr(pdlc_pkg::ADDR_SLEW, 8'(r));
         wr(pdlc_pkg::ADDR_CORE_CODE, {3'h0, tgt});
         wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h87);
         wait_idle(n);
         `CHK(core_code, tgt)
         `CHK(n >= 3 * iv && n <= 4 * iv + 6, 1'h1)
      end
      // Retarget in mid-ramp continues from the current code
      wr(pdlc_pkg::ADDR_SLEW, 8'h03);
      wr(pdlc_pkg::ADDR_CORE_CODE, 8'h10);
      wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h87);
      cyc(40);
      mid = core_code;
      `CHK(mid > 5'h10 && mid < 5'h1C && busy, 1'h1)
      wr(pdlc_pkg::ADDR_CORE_CODE, 8'h1E);
      wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h87);
      wait_idle(n);
      `CHK(core_code, 5'h1E)
      `CHK(n >= (28 - int'(mid)) * 8, 1'h1)
      // Clock enable low freezes a ramp in flight
      wr(pdlc_pkg::ADDR_CORE_CODE, 8'h10);
      wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h87);
      cyc(20);
      clk_en <= 1'h0;
      cyc(2);
      mid = core_code;
      cyc(30);
      `CHK(core_code, mid)
      `CHK(busy, 1'h1)
      clk_en <= 1'h1;
      wait_idle(n);
      `CHK(core_code, 5'h10)
      // Every reset source, with the core and linear a default pins changed
      core_pin <= 1'h1;
      pin_a <= 1'h1;
      for (int s = 0; s < 4; s++) begin
         wr(pdlc_pkg::ADDR_CONV_CTRL2, 8'h00);
         wr(pdlc_pkg::ADDR_CORE_CODE, 8'h05);
         wr(pdlc_pkg::ADDR_SLEW, 8'h03);
         wr(pdlc_pkg::ADDR_LIN, 8'h00);
         src <= 4'(1 << s);
         cyc(4);
         src <= 4'h0;
         cyc(6);
         chk_reg(pdlc_pkg::ADDR_CONV_CTRL2, 8'h40);
         chk_reg(pdlc_pkg::ADDR_CORE_CODE, 8'h1E);
         chk_reg(pdlc_pkg::ADDR_SLEW, s == 1 ? 8'h06 : 8'h03);
         chk_reg(pdlc_pkg::ADDR_LIN, s == 1 ? 8'h35 : 8'h00);
         `CHK(core_code, 5'h1F)
      end
      tally_and_finish();
   end

   // Whole run needs about 1000 cycles
   initial begin
      cyc(20000);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
